// file: inc/pqmap_cfg.svh
//------------------------------------------------------------------------------
// Purpose: Constants of the priority queue map and event-flag register slice.
// Assumes: Byte-wide register port, one register per printed address.
// Notes:   Definitions only; included by its bare name.
//------------------------------------------------------------------------------
// Functional notes
// - Read-only per-port event flags, reset zero.
// - Read-write per-port event enables, reset disabled.
// - Map eight priority codes onto four queues.
// - Codes 0,1 from low map, reset queue 0.
// - Codes 2,3 from low map, reset queue 1.
// - Codes 4,5 from high map, reset queue 2.
// - Codes 6,7 from high map, reset queue 3.
// - Two-queue mode reduces result by split field.
// - Result 0 low, result 3 high always.
// - Results 1 and 2 follow split bits.
// - Split 00, 10, 11 give documented partitions.
// - Split field resets to binary 10.
`ifndef PQMAP_CFG_SVH
`define PQMAP_CFG_SVH

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define ACL_FLAGS_ADDR 8'h7e
`define ACL_ENABLES_ADDR 8'h7f
`define MAP_LOW_ADDR 8'h80
`define MAP_HIGH_ADDR 8'h81
`define SPLIT_CTRL_ADDR 8'h82

// ------------------------------------------------------------
// Reset values and fixed read-back fields
// ------------------------------------------------------------
`define ACL_FLAGS_RST 5'h00
`define ACL_ENABLES_RST 5'h00
`define MAP_LOW_RST 8'h50
`define MAP_HIGH_RST 8'hfa
`define SPLIT_RST 2'h2
`define SPLIT_RSVD_VAL 6'h08
`define RSVD3_VAL 3'h0
`define RDATA_RST 8'h00
`define QUEUE_RST 2'h0

// ------------------------------------------------------------
// Field positions and queue codes
// ------------------------------------------------------------
`define PORT_MSB 4
`define SPLIT_MSB 7
`define SPLIT_LSB 6
`define Q_LOWEST 2'h0
`define Q_HIGHEST 2'h3
`define Q_ONE 2'h1
`define Q_TWO 2'h2

`endif

// file: inc/pqmap_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Types shared by the priority queue map design files.
// Assumes: Five switch ports, four egress queues.
// Notes:   Numeric constants live in the configuration header.
//------------------------------------------------------------------------------
package pqmap_pkg;
  // Egress queue number, 3 highest, 0 lowest.
  typedef logic [1:0] queue_type;
  // One bit per switch port.
  typedef logic [4:0] port_vec_type;
  // Register byte and address.
  typedef logic [7:0] byte_type;
  // Frame priority code from the tag.
  typedef logic [2:0] pcp_type;
endpackage

// file: logic/priority_queue_map_acl_irq.sv
//------------------------------------------------------------------------------
// Purpose: Event flags with enables, and the priority-code queue map.
// Assumes: Byte register port synchronous to CLK_SYS_I; one access a cycle.
// Notes:   Flags clear on read of their register; a new event wins.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`include "pqmap_cfg.svh"

module priority_queue_map_acl_irq (
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire pqmap_pkg::byte_type REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire pqmap_pkg::byte_type REG_WDATA_I,
  output pqmap_pkg::byte_type REG_RDATA_O,
  input wire pqmap_pkg::port_vec_type ACL_EVENT_I,
  output logic ACL_IRQ_O,
  input wire logic LOOKUP_VALID_I,
  input wire pqmap_pkg::pcp_type PCP_I,
  input wire logic TOS_SEL_I,
  input wire pqmap_pkg::queue_type TOS_RESULT_I,
  input wire logic TWO_QUEUE_MODE_I,
  output logic QUEUE_VALID_O,
  output pqmap_pkg::queue_type QUEUE_O,
  output logic QUEUE_HIGH_O
);
  import pqmap_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Sticky per-port event flags.
  port_vec_type acl_event_flag_bits_r;
  port_vec_type acl_event_flag_bits_nxt;
  // Per-port interrupt enables.
  port_vec_type acl_event_enable_bits_r;
  // Mapping bytes for codes 0-3 and 4-7.
  byte_type map_low_r;
  byte_type map_high_r;
  // Two-queue split field.
  logic [1:0] two_queue_split_r;
  // Registered read data.
  byte_type rdata_r;
  // Per-code queue table unpacked from the map bytes.
  queue_type pcp_queue_sel [8];
  // Four-queue result and its two-queue reduction.
  queue_type four_q_result;
  logic reduced_high;
  // Registered lookup outputs.
  logic queue_valid_r;
  queue_type queue_r;
  logic queue_high_r;

  // Decoded strobes.
  logic wr_enables;
  logic wr_map_low;
  logic wr_map_high;
  logic wr_split;
  logic rd_flags;

  assign wr_enables = REG_WR_I && (REG_ADDR_I == `ACL_ENABLES_ADDR);
  assign wr_map_low = REG_WR_I && (REG_ADDR_I == `MAP_LOW_ADDR);
  assign wr_map_high = REG_WR_I && (REG_ADDR_I == `MAP_HIGH_ADDR);
  assign wr_split = REG_WR_I && (REG_ADDR_I == `SPLIT_CTRL_ADDR);
  assign rd_flags = REG_RD_I && (REG_ADDR_I == `ACL_FLAGS_ADDR);

  // ------------------------------------------------------------
  // Event flags
  // ------------------------------------------------------------
  // Read clears the flags it returned; an event in the same cycle
  // sets again so it is never lost. Writes to the flags are ignored.
  always_comb begin
    acl_event_flag_bits_nxt = acl_event_flag_bits_r;
    if (rd_flags) begin
      acl_event_flag_bits_nxt = `ACL_FLAGS_RST;
    end
    acl_event_flag_bits_nxt = acl_event_flag_bits_nxt | ACL_EVENT_I;
  end

  // Flag register.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      acl_event_flag_bits_r <= `ACL_FLAGS_RST;
    end else begin
      acl_event_flag_bits_r <= acl_event_flag_bits_nxt;
    end
  end

  // Enable register, fully writable in its low five bits.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      acl_event_enable_bits_r <= `ACL_ENABLES_RST;
    end else if (wr_enables) begin
      acl_event_enable_bits_r <= REG_WDATA_I[`PORT_MSB:0];
    end
  end

  // Interrupt straight from flags and enables, no extra latency.
  assign ACL_IRQ_O = |(acl_event_flag_bits_r & acl_event_enable_bits_r);

  // ------------------------------------------------------------
  // Mapping and split registers
  // ------------------------------------------------------------
  // Low map byte: codes 0,1 reset to queue 0, codes 2,3 to queue 1.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      map_low_r <= `MAP_LOW_RST;
    end else if (wr_map_low) begin
      map_low_r <= REG_WDATA_I;
    end
  end

  // High map byte: codes 4,5 reset to queue 2, codes 6,7 to queue 3.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      map_high_r <= `MAP_HIGH_RST;
    end else if (wr_map_high) begin
      map_high_r <= REG_WDATA_I;
    end
  end

  // Split field; the value 01 is accepted but has no defined meaning,
  // so the result then is whatever the per-bit decode gives.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      two_queue_split_r <= `SPLIT_RST;
    end else if (wr_split) begin
      two_queue_split_r <= REG_WDATA_I[`SPLIT_MSB:`SPLIT_LSB];
    end
  end

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  // Read data appear one cycle after the strobe; unmapped reads give 0.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rdata_r <= `RDATA_RST;
    end else if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        `ACL_FLAGS_ADDR: begin
          rdata_r <= {`RSVD3_VAL, acl_event_flag_bits_r};
        end
        `ACL_ENABLES_ADDR: begin
          rdata_r <= {`RSVD3_VAL, acl_event_enable_bits_r};
        end
        `MAP_LOW_ADDR: rdata_r <= map_low_r;
        `MAP_HIGH_ADDR: rdata_r <= map_high_r;
        `SPLIT_CTRL_ADDR: begin
          rdata_r <= {two_queue_split_r, `SPLIT_RSVD_VAL};
        end
        default: rdata_r <= `RDATA_RST;
      endcase
    end
  end

  assign REG_RDATA_O = rdata_r;

  // ------------------------------------------------------------
  // Priority code lookup
  // ------------------------------------------------------------
  // Each code owns a two-bit field; codes 0-3 sit in the low byte.
  for (genvar g = 0; g < 8; g++) begin : g_pcp
    if (g < 4) begin : g_lo
      assign pcp_queue_sel[g] = map_low_r[2*g+1:2*g];
    end else begin : g_hi
      assign pcp_queue_sel[g] = map_high_r[2*g-7:2*g-8];
    end
  end

  // Either table may supply the four-queue result.
  assign four_q_result = TOS_SEL_I ? TOS_RESULT_I
                                   : pcp_queue_sel[PCP_I];

  two_queue_reduce u_reduce (
    .result_i(four_q_result),
    .two_queue_split_i(two_queue_split_r),
    .high_o(reduced_high)
  );

  // Outputs registered one cycle after the lookup; the high flag only
  // means something in two-queue mode and a lookup made outside it loads 0.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      queue_valid_r <= 1'b0;
      queue_r <= `QUEUE_RST;
      queue_high_r <= 1'b0;
    end else begin
      queue_valid_r <= LOOKUP_VALID_I;
      if (LOOKUP_VALID_I) begin
        queue_r <= four_q_result;
        queue_high_r <= TWO_QUEUE_MODE_I && reduced_high;
      end
    end
  end

  assign QUEUE_VALID_O = queue_valid_r;
  assign QUEUE_O = queue_r;
  assign QUEUE_HIGH_O = queue_high_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  flag_set_a: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    ACL_EVENT_I[0] |=> acl_event_flag_bits_r[0] ##1
    (acl_event_flag_bits_r[0] || $past(rd_flags)))
    else $error("event flag did not hold after event");

  flag_cause_a: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    $rose(acl_event_flag_bits_r[1]) |-> $past(ACL_EVENT_I[1]))
    else $error("event flag rose without an event");

  enable_write_a: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    wr_enables |=> acl_event_enable_bits_r == $past(REG_WDATA_I[4:0]))
    else $error("enable write not stored");

  irq_raise_a: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (ACL_EVENT_I[2] && acl_event_enable_bits_r[2] && !wr_enables)
    |=> ACL_IRQ_O)
    else $error("interrupt missing for enabled event");

  pcp_lookup_a: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (LOOKUP_VALID_I && !TOS_SEL_I && PCP_I == 3'h7)
    |=> QUEUE_O == $past(map_high_r[7:6]))
    else $error("code 7 queue not from high map top field");

  map_low_write_a: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    wr_map_low |=> map_low_r == $past(REG_WDATA_I))
    else $error("low map write not stored");

  map_high_write_a: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    wr_map_high |=> map_high_r == $past(REG_WDATA_I))
    else $error("high map write not stored");

  ends_fixed_a: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (LOOKUP_VALID_I && TWO_QUEUE_MODE_I && four_q_result == `Q_HIGHEST)
    |=> QUEUE_HIGH_O)
    else $error("result 3 not sent to high queue");

  split_mid_a: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (LOOKUP_VALID_I && TWO_QUEUE_MODE_I && four_q_result == `Q_TWO)
    |=> QUEUE_HIGH_O == $past(two_queue_split_r[1]))
    else $error("result 2 ignored split bit 1");

  four_q_mode_a: assert property (
    @(posedge CLK_SYS_I) disable iff (!RST_B_I)
    (LOOKUP_VALID_I && !TWO_QUEUE_MODE_I) |=> !QUEUE_HIGH_O)
    else $error("high flag set outside two-queue mode");
endmodule // priority_queue_map_acl_irq

// file: logic/two_queue_reduce.sv
//------------------------------------------------------------------------------
// Purpose: Collapse a four-queue result onto a low/high queue choice.
// Assumes: Split value 01 is never programmed by software.
// Notes:   Purely combinational; the caller registers the answer.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
`include "pqmap_cfg.svh"

module two_queue_reduce (
  input wire pqmap_pkg::queue_type result_i,
  input wire logic [1:0] two_queue_split_i,
  output logic high_o
);
  import pqmap_pkg::*;

  // ------------------------------------------------------------
  // Reduction
  // ------------------------------------------------------------
  // Ends are fixed; middle results follow one split bit each. The
  // unsupported split 01 simply falls out of the per-bit decode.
  always_comb begin
    unique case (result_i)
      `Q_LOWEST: high_o = 1'b0;
      `Q_ONE: high_o = two_queue_split_i[0];
      `Q_TWO: high_o = two_queue_split_i[1];
      `Q_HIGHEST: high_o = 1'b1;
    endcase
  end
endmodule // two_queue_reduce

// file: tb/testbench.sv
// Purpose: Self-checking bench for the priority queue map register slice.
// Assumes: Inputs change on the falling clock edge; one access at a time.
// Notes:   Expected values come from the register table, not from the design.
`timescale 1ns/1ps

module testbench;
  import pqmap_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'b0; // System clock, 100 MHz.
  logic rst_b = 1'b0; // Active-low reset.
  byte_type addr = 8'h00; // Register address.
  logic wr = 1'b0; // Write strobe.
  logic rd = 1'b0; // Read strobe.
  byte_type wdata = 8'h00; // Write data.
  byte_type rdata; // Read data.
  port_vec_type ev = 5'h00; // Per-port events.
  logic irq; // Event interrupt.
  logic lk_vld = 1'b0; // Lookup request.
  pcp_type pcp = 3'h0; // Priority code.
  logic tos_sel = 1'b0; // Use the ToS result.
  queue_type tos_res = 2'h0; // ToS four-queue result.
  logic two_q = 1'b0; // Two-queue mode.
  logic q_vld; // Lookup answer valid.
  queue_type q; // Four-queue result.
  logic q_high; // Two-queue high choice.
  int error_cnt = 0; // Mismatches seen.
  int checks = 0; // Comparisons made.

  // ----------------------------------------------------------------
  // Clock and design under test
  // ----------------------------------------------------------------
  // Free-running clock, half period 5 ns.
  always #5 clk = ~clk;

  priority_queue_map_acl_irq u_dut (
    .CLK_SYS_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .ACL_EVENT_I(ev), .ACL_IRQ_O(irq), .LOOKUP_VALID_I(lk_vld),
    .PCP_I(pcp), .TOS_SEL_I(tos_sel), .TOS_RESULT_I(tos_res),
    .TWO_QUEUE_MODE_I(two_q), .QUEUE_VALID_O(q_vld), .QUEUE_O(q),
    .QUEUE_HIGH_O(q_high)
  );

  // ----------------------------------------------------------------
  // Compare tasks, one per kind of result
  // ----------------------------------------------------------------
  // Case equality so that an unknown never passes for a match.
  task automatic chk_byte(input string nm, input byte_type e, byte_type g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_q(input string nm, input queue_type e, queue_type g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, logic g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus and lookup tasks
  // ----------------------------------------------------------------
  // One-cycle write strobe; data is stored at the rising edge.
  task automatic reg_wr(input byte_type a, input byte_type d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // One-cycle read strobe; data stands from the following cycle on.
  task automatic reg_rd(input byte_type a, output byte_type d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask

  // Reads a register and compares it with the expected byte.
  task automatic rd_chk(input string nm, input byte_type a, byte_type e);
    byte_type d;
    reg_rd(a, d);
    chk_byte(nm, e, d);
  endtask

  // One lookup; the answer is registered one cycle later.
  task automatic lookup(input pcp_type p, input logic ts, queue_type tr,
                        input queue_type eq, input logic eh);
    @(negedge clk);
    lk_vld = 1'b1;
    pcp = p;
    tos_sel = ts;
    tos_res = tr;
    @(negedge clk);
    lk_vld = 1'b0;
    chk_bit("queue_valid", 1'b1, q_vld);
    chk_q("queue", eq, q);
    chk_bit("queue_high", eh, q_high);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, reserved bits, read-only flags and an unmapped read.
  task automatic test_regs();
    rd_chk("flags_rst", 8'h7e, 8'h00);
    rd_chk("enables_rst", 8'h7f, 8'h00);
    rd_chk("map_low_rst", 8'h80, 8'h50);
    rd_chk("map_high_rst", 8'h81, 8'hfa);
    rd_chk("split_rst", 8'h82, 8'h88);
    rd_chk("unmapped", 8'h83, 8'h00);
    reg_wr(8'h7e, 8'hff);
    rd_chk("flags_ro", 8'h7e, 8'h00);
    reg_wr(8'h7f, 8'hff);
    rd_chk("enables_rw", 8'h7f, 8'h1f);
    reg_wr(8'h7f, 8'h00);
    $display("test_regs done");
  endtask

  // A flag is set by an event and cleared by a read; its enable gates the interrupt.
  // An event in the very cycle of the read must survive the clear.
  task automatic test_flags();
    @(negedge clk);
    ev = 5'h07;
    @(negedge clk);
    ev = 5'h00;
    chk_bit("irq_disabled", 1'b0, irq);
    reg_wr(8'h7f, 8'h04);
    chk_bit("irq_enabled", 1'b1, irq);
    rd_chk("flags_set", 8'h7e, 8'h07);
    chk_bit("irq_cleared", 1'b0, irq);
    // Read and a new enabled event share one cycle.
    @(negedge clk);
    addr = 8'h7e;
    rd = 1'b1;
    ev = 5'h04;
    @(negedge clk);
    rd = 1'b0;
    ev = 5'h00;
    chk_byte("flags_empty", 8'h00, rdata);
    chk_bit("irq_set_wins", 1'b1, irq);
    rd_chk("flags_kept", 8'h7e, 8'h04);
    rd_chk("flags_clear", 8'h7e, 8'h00);
    $display("test_flags done");
  endtask

  // Split values 10, 00 and 11 against all four results, from both tables.
  task automatic test_split();
    logic [1:0] sv[3] = '{2'h2, 2'h0, 2'h3};
    // Lowest result that each split value sends to the high queue.
    int lowest_high[3] = '{2, 3, 1};
    logic eh;
    two_q = 1'b1;
    foreach (sv[i]) begin
      // The first pass relies on the reset value of the split field.
      if (i > 0) reg_wr(8'h82, {sv[i], 6'h00});
      rd_chk("split_rd", 8'h82, {sv[i], 6'h08});
      for (int r = 0; r < 4; r++) begin
        eh = (r >= lowest_high[i]);
        lookup(3'h0, 1'b1, r[1:0], r[1:0], eh);
        lookup(3'(2 * r), 1'b0, 2'h0, r[1:0], eh);
      end
    end
    two_q = 1'b0;
    $display("test_split done");
  endtask

  // Every priority code through the reset map and a rewritten map.
  task automatic test_map();
    byte_type lo = 8'h1b;
    byte_type hi = 8'he4;
    byte_type m;
    for (int p = 0; p < 8; p++)
      lookup(p[2:0], 1'b0, 2'h3, p[2:1], 1'b0);
    reg_wr(8'h80, lo);
    reg_wr(8'h81, hi);
    rd_chk("map_low_rw", 8'h80, lo);
    rd_chk("map_high_rw", 8'h81, hi);
    for (int p = 0; p < 8; p++) begin
      m = (p < 4) ? lo : hi;
      m = m >> (2 * (p % 4));
      lookup(p[2:0], 1'b0, 2'h0, m[1:0], 1'b0);
    end
    // With no request the valid drops and the last queue stays.
    @(negedge clk);
    chk_bit("queue_valid_idle", 1'b0, q_vld);
    chk_q("queue_held", 2'h3, q);
    $display("test_map done");
  endtask

  // ----------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------------
  // Single place where the run ends.
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Reset for three cycles, then each scenario in turn.
  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    test_regs();
    test_flags();
    test_split();
    test_map();
    summarize();
  end

  // The scenarios take well under 500 cycles; 2000 means a hang.
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
endmodule // testbench
